// ===== logic/scp_pkg.sv
package scp_pkg;

    // register space seen over the serial link
    localparam logic [9:0] ADDR_TOP     = 10'h232; // last mapped address
    localparam int         NUM_REGS     = 563;     // ADDR_TOP + 1 entries
    localparam logic [9:0] REG_PORT_CFG = 10'h000; // port configuration
    localparam logic [9:0] REG_RB_SEL   = 10'h004; // readback source select
    localparam logic [9:0] REG_UPDATE   = 10'h232; // update command
    localparam int         BIT_SDO_EN   = 7;       // separate line enable
    localparam int         BIT_LSB      = 1;       // bit order select
    localparam int         BIT_RB_SEL   = 0;       // 1: active, 0: shadow
    localparam int         BIT_UPDATE   = 0;       // self-clearing update
    localparam logic [7:0] PORT_CFG_RST = 8'h18;   // long instruction mode

    // instruction word layout
    localparam int         INSTR_RW     = 15;      // 1 = read
    localparam int         INSTR_LEN_HI = 14;
    localparam int         INSTR_LEN_LO = 13;
    localparam logic [3:0] INSTR_LAST   = 4'hF;    // sixteenth bit index
    localparam logic [3:0] BYTE_LAST    = 4'h7;    // eighth bit index
    localparam logic [3:0] INSTR_MID    = 4'h8;    // instruction byte edge
    localparam logic [1:0] LEN_STREAM   = 2'h3;    // transfer ends at ADDR_TOP

    // software register map (byte offsets)
    localparam int         AXI_AW       = 8;
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_PEEKADR  = 8'h04;
    localparam logic [7:0] OFF_PEEKDAT  = 8'h08;
    localparam logic [7:0] OFF_BYTECNT  = 8'h0C;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {IDLE, INSTR, DATA, STALL, DONE} phase_e;

    // pins arriving from the host
    typedef struct packed {
        logic csN;   // port select, active low
        logic sclk;  // serial clock
        logic sdi;   // shared data line, input side
    } link_in_s;

    // pins driven toward the host
    typedef struct packed {
        logic sdioOut;   // shared data line, output side
        logic sdioOeN;   // low while driving the shared line
        logic rbOut;     // separate_readback_line
        logic rbOeN;     // low while driving the separate line
    } link_out_s;

endpackage : scp_pkg

// ===== logic/serial_control_port_target.sv
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module serial_control_port_target
    import scp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire link_in_s          linkIn,
    output link_out_s              linkOut,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // state
    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [1:0]        csSync;    // port select synchroniser
        logic [1:0]        sclkSync;  // serial clock synchroniser
        logic [1:0]        sdiSync;   // data synchroniser
        logic              csPrev;    // settled port select, last cycle
        logic              sclkPrev;  // settled serial clock, last cycle
        phase_e            phase;     // transfer phase
        phase_e            resume;    // phase to return to after a stall
        logic              rd;        // current transfer is a read
        logic [1:0]        len;       // transfer_length_code
        logic [9:0]        addr;      // current register address
        logic [15:0]       instr;     // instruction shifter
        logic [7:0]        byteSr;    // write data shifter
        logic [3:0]        bitCnt;    // bits taken in current unit
        logic [1:0]        byteCnt;   // data bytes done, short transfers
        logic [7:0]        outByte;   // readback byte being shifted
        logic              lsbFirst;  // bit order, live at once
        logic              sdoEn;     // readback on separate line
        link_out_s         pins;      // registered pin drive
        logic              awHeld;    // write address captured
        logic              wHeld;     // write data captured
        logic [AXI_AW-1:0] awAddr;
        logic [31:0]       wData;
        logic [3:0]        wStrb;
        logic              awRdy;
        logic              wRdy;
        logic              bValid;
        logic [1:0]        bResp;
        logic              arRdy;
        logic              rValid;
        logic [1:0]        rResp;
        logic [31:0]       rData;
        logic [9:0]        peekAddr;  // active register shown to software
        logic [15:0]       byteTotal; // data bytes moved over the link
    } state_s;

    state_s     q;               // registered state
    state_s     s;               // next state
    logic [7:0] shadowMem [NUM_REGS];  // buffer written by the host
    logic [7:0] activeMem [NUM_REGS];  // registers in effect
    logic       memWe;           // store one byte into the buffer
    logic [9:0] memWAddr;        // buffer address to store
    logic [7:0] memWData;        // byte to store
    logic       doUpdate;        // copy buffer into active registers

    // byte readback at an address, from buffer or active copy
    function automatic logic [7:0] readByte(input logic [9:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a <= ADDR_TOP) begin
            if (activeMem[REG_RB_SEL][BIT_RB_SEL]) begin
                v = activeMem[a];
            end else begin
                v = shadowMem[a];
            end
        end
        return v;
    endfunction : readByte

    ////////////////////////////////////////////////////////////////////////
    // link and bus next-state logic
    ////////////////////////////////////////////////////////////////////////

    logic       csNow;     // settled port select
    logic       sclkNow;   // settled serial clock
    logic       sdiNow;    // settled data bit
    logic       sRise;     // serial clock rising
    logic       sFall;     // serial clock falling
    logic       csRise;    // port select released
    logic       csFall;    // port select asserted
    logic [15:0] instrNx;  // instruction after this bit
    logic [7:0]  byteNx;   // write byte after this bit
    logic [9:0]  addrNx;   // address after a data byte
    logic        lastByte; // the byte just finished ends the transfer
    logic [31:0] rdWord;   // software read value

    always_comb begin
        s        = q;
        memWe    = 1'b0;
        memWAddr = q.addr;
        memWData = 8'h00;
        doUpdate = 1'b0;
        rdWord   = 32'h0000_0000;
        // two flip-flops on every pin before use
        s.csSync   = {q.csSync[0], linkIn.csN};
        s.sclkSync = {q.sclkSync[0], linkIn.sclk};
        s.sdiSync  = {q.sdiSync[0], linkIn.sdi};
        csNow      = q.csSync[1];
        sclkNow    = q.sclkSync[1];
        sdiNow     = q.sdiSync[1];
        s.csPrev   = csNow;
        s.sclkPrev = sclkNow;
        sRise      = sclkNow & ~q.sclkPrev;
        sFall      = ~sclkNow & q.sclkPrev;
        csRise     = csNow & ~q.csPrev;
        csFall     = ~csNow & q.csPrev;
        // shifters follow the live bit order
        instrNx = q.lsbFirst ? {sdiNow, q.instr[15:1]}
                             : {q.instr[14:0], sdiNow};
        byteNx  = q.lsbFirst ? {sdiNow, q.byteSr[7:1]}
                             : {q.byteSr[6:0], sdiNow};
        // address stepping with wrap at both ends of the space
        if (q.lsbFirst) begin
            addrNx = (q.addr >= ADDR_TOP) ? 10'h000 : q.addr + 10'h001;
        end else begin
            addrNx = (q.addr == 10'h000) ? ADDR_TOP : q.addr - 10'h001;
        end
        lastByte = (q.len == LEN_STREAM) ? (q.addr == ADDR_TOP)
                                         : (q.byteCnt == q.len);

        // transfer sequencing
        case (q.phase)
            IDLE: begin
                // a transfer opens when port select falls
                if (csFall) begin
                    s.phase  = INSTR;
                    s.bitCnt = 4'h0;
                    s.instr  = 16'h0000;
                end
            end
            INSTR: begin
                if (csRise) begin
                    // byte edge inside the instruction may stall
                    if (q.bitCnt == INSTR_MID) begin
                        s.phase  = STALL;
                        s.resume = INSTR;
                    end else begin
                        s.phase = IDLE;
                    end
                end else if (sRise) begin
                    s.instr  = instrNx;
                    s.bitCnt = 4'(q.bitCnt + 4'h1);
                    if (q.bitCnt == INSTR_LAST) begin
                        s.rd      = instrNx[INSTR_RW];
                        s.len     = instrNx[INSTR_LEN_HI:INSTR_LEN_LO];
                        s.addr    = instrNx[9:0];
                        s.bitCnt  = 4'h0;
                        s.byteCnt = 2'h0;
                        s.outByte = readByte(instrNx[9:0]);
                        s.phase   = DATA;
                    end
                end
            end
            DATA: begin
                if (csRise) begin
                    if (q.bitCnt != 4'h0) begin
                        s.phase = IDLE;
                    end else if (q.len == LEN_STREAM) begin
                        s.phase = IDLE;
                    end else begin
                        s.phase  = STALL;
                        s.resume = DATA;
                    end
                end else if (sFall && q.rd) begin
                    // launch the next readback bit
                    if (q.sdoEn) begin
                        s.pins.rbOut = q.lsbFirst ? q.outByte[q.bitCnt[2:0]]
                                     : q.outByte[3'(BYTE_LAST - q.bitCnt)];
                        s.pins.rbOeN = 1'b0;
                    end else begin
                        s.pins.sdioOut = q.lsbFirst
                                       ? q.outByte[q.bitCnt[2:0]]
                                       : q.outByte[3'(BYTE_LAST - q.bitCnt)];
                        s.pins.sdioOeN = 1'b0;
                    end
                end else if (sRise) begin
                    s.byteSr = byteNx;
                    s.bitCnt = 4'(q.bitCnt + 4'h1);
                    if (q.bitCnt == BYTE_LAST) begin
                        s.bitCnt    = 4'h0;
                        s.byteCnt   = 2'(q.byteCnt + 2'h1);
                        s.byteTotal = 16'(q.byteTotal + 16'h0001);
                        if (!q.rd && (q.addr <= ADDR_TOP)) begin
                            memWe    = 1'b1;
                            memWData = byteNx;
                            if (q.addr == REG_UPDATE) begin
                                doUpdate = byteNx[BIT_UPDATE];
                                memWData[BIT_UPDATE] = 1'b0;
                            end
                            if (q.addr == REG_PORT_CFG) begin
                                s.lsbFirst = byteNx[BIT_LSB];
                                s.sdoEn    = byteNx[BIT_SDO_EN];
                            end
                        end
                        if (lastByte) begin
                            s.phase = DONE;
                        end else begin
                            s.addr    = addrNx;
                            s.outByte = readByte(addrNx);
                        end
                    end
                end
            end
            STALL: begin
                // wait with select high until the host picks up again
                if (csFall) begin
                    s.phase = q.resume;
                end
            end
            DONE: begin
                if (csRise) begin
                    s.phase = IDLE;
                end
            end
            default: begin
                s.phase = IDLE;
            end
        endcase

        // release both lines outside a read data phase
        if (csNow || (s.phase != DATA) || !q.rd) begin
            s.pins.sdioOeN = 1'b1;
            s.pins.rbOeN   = 1'b1;
        end

        // software write: address and data in either order
        if (s_axi_awvalid && q.awRdy) begin
            s.awHeld = 1'b1;
            s.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wRdy) begin
            s.wHeld = 1'b1;
            s.wData = s_axi_wdata;
            s.wStrb = s_axi_wstrb;
        end
        if (q.bValid && s_axi_bready) begin
            s.bValid = 1'b0;
        end
        if (q.awHeld && q.wHeld && !q.bValid) begin
            s.awHeld = 1'b0;
            s.wHeld  = 1'b0;
            s.bValid = 1'b1;
            s.bResp  = RESP_OKAY;
            case ({q.awAddr[AXI_AW-1:2], 2'b00})
                OFF_PEEKADR: begin
                    if (q.wStrb[0]) s.peekAddr[7:0] = q.wData[7:0];
                    if (q.wStrb[1]) s.peekAddr[9:8] = q.wData[9:8];
                end
                OFF_STATUS, OFF_PEEKDAT, OFF_BYTECNT: begin
                    s.bResp = RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    s.bResp = RESP_SLVERR;
                end
            endcase
        end
        s.awRdy = !s.awHeld && !s.bValid;
        s.wRdy  = !s.wHeld && !s.bValid;

        // software read, answered one cycle after acceptance
        if (q.rValid && s_axi_rready) begin
            s.rValid = 1'b0;
        end
        if (s_axi_arvalid && q.arRdy) begin
            s.rValid = 1'b1;
            s.rResp  = RESP_OKAY;
            case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
                OFF_STATUS: begin
                    rdWord = {24'h000000, q.sdoEn, q.lsbFirst, q.rd,
                              ~csNow, 1'b0, q.phase};
                end
                OFF_PEEKADR: rdWord = {22'h000000, q.peekAddr};
                OFF_PEEKDAT: begin
                    if (q.peekAddr <= ADDR_TOP) begin
                        rdWord = {24'h000000, activeMem[q.peekAddr]};
                    end
                end
                OFF_BYTECNT: rdWord = {16'h0000, q.byteTotal};
                default: s.rResp = RESP_SLVERR;
            endcase
            s.rData = rdWord;
        end
        s.arRdy = !s.rValid;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    ////////////////////////////////////////////////////////////////////////

    // reset: shared line, msb first, both lines released
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q          <= '0;
            q.csSync   <= 2'h3;
            q.csPrev   <= 1'b1;
            q.phase    <= IDLE;
            q.resume   <= IDLE;
            q.lsbFirst <= 1'b0;
            q.sdoEn    <= 1'b0;
            q.pins     <= '{sdioOut: 1'b0, sdioOeN: 1'b1,
                            rbOut: 1'b0, rbOeN: 1'b1};
            q.awRdy    <= 1'b1;
            q.wRdy     <= 1'b1;
            q.arRdy    <= 1'b1;
        end else begin
            q <= s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer and active register arrays
    ////////////////////////////////////////////////////////////////////////

    // buffer takes host bytes; update copies the whole buffer at once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shadowMem[i] <= 8'h00;
                activeMem[i] <= 8'h00;
            end
            shadowMem[REG_PORT_CFG] <= PORT_CFG_RST;
            activeMem[REG_PORT_CFG] <= PORT_CFG_RST;
        end else begin
            if (doUpdate) begin
                for (int i = 0; i < NUM_REGS; i++) begin
                    activeMem[i] <= shadowMem[i];
                end
            end
            if (memWe) begin
                shadowMem[memWAddr] <= memWData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////////

    assign linkOut       = q.pins;
    assign s_axi_awready = q.awRdy;
    assign s_axi_wready  = q.wRdy;
    assign s_axi_bvalid  = q.bValid;
    assign s_axi_bresp   = q.bResp;
    assign s_axi_arready = q.arRdy;
    assign s_axi_rvalid  = q.rValid;
    assign s_axi_rresp   = q.rResp;
    assign s_axi_rdata   = q.rData;

endmodule : serial_control_port_target

// ===== test/scp_props.sv
`timescale 1ns/1ns
module scp_props
    import scp_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire link_in_s    linkIn,
    input wire link_out_s   linkOut,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // both halves of a write taken at one edge
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // select seen high long enough to pass the synchronisers
    sequence linkIdle;
        linkIn.csN [*5];
    endsequence
    ////////////////////////////////////////////////////////////////////
    AST_IDLE_RELEASED: assert property (
        linkIdle |-> linkOut.sdioOeN && linkOut.rbOeN)
        else $error("data line driven while deselected");
    AST_ONE_LINE: assert property (
        !(!linkOut.sdioOeN && !linkOut.rbOeN))
        else $error("both readback lines driven");
    AST_DRIVE_SELECTED: assert property (
        $fell(linkOut.sdioOeN) |-> !linkIn.csN)
        else $error("shared line driven without select");
    AST_HOLD_AFTER_RISE: assert property (
        $rose(linkIn.sclk) && !(linkOut.sdioOeN && linkOut.rbOeN)
        |=> $stable({linkOut.sdioOut, linkOut.rbOut}) [*2])
        else $error("readback bit moved after rising clock");
    AST_B_AFTER_TAKE: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_B_CLOSE: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened");
    AST_R_AFTER_TAKE: assert property (rdTaken
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_R_CLOSE: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
endmodule : scp_props

bind serial_control_port_target scp_props props (.core_clk, .rst,
    .linkIn, .linkOut, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);

// ===== test/host_model.sv
`timescale 1ns/1ns
module host_model
    import scp_pkg::*;
(
    input  wire logic      core_clk,
    input  wire link_out_s linkOut,
    input  wire logic      useSep,
    output logic           csN,
    output logic           sclk,
    output logic           hostDrv
);
    logic line; // level on the line the host listens to
    // an undriven line shows the inverse of the last host bit
    assign line = useSep ? (linkOut.rbOeN ? ~hostDrv : linkOut.rbOut)
                         : (linkOut.sdioOeN ? ~hostDrv : linkOut.sdioOut);
    initial begin
        csN = 1'h1;
        sclk = 1'h0;
        hostDrv = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////
    // select drops before any clock edge
    task automatic selLow();
        csN <= 1'h0;
        repeat (3) @(posedge core_clk);
    endtask : selLow
    // msb first: fall, five low, capture and rise, three high
    task automatic shift(input logic [31:0] v, input int n,
                         output logic [31:0] r);
        r = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'h0;
            hostDrv <= v[i];
            repeat (5) @(posedge core_clk);
            r[i] = line;
            sclk <= 1'h1;
            repeat (3) @(posedge core_clk);
        end
    endtask : shift
    // frame ends: select high, clock parked low
    task automatic selHigh();
        csN <= 1'h1;
        hostDrv <= ~hostDrv;
        @(posedge core_clk);
        sclk <= 1'h0;
        repeat (8) @(posedge core_clk);
    endtask : selHigh
endmodule : host_model

// ===== test/tb.sv
`timescale 1ns/1ns
module tb
    import scp_pkg::*;
;
    logic        core_clk = 1'h0, rst = 1'h1, useSep = 1'h0;
    logic        csN, sclk, hostDrv;
    link_in_s    linkIn;
    link_out_s   linkOut;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, junk;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          errors = 0, compares = 0, cycles = 0;
    // device wins the shared line while it drives
    assign linkIn = {csN, sclk,
                     linkOut.sdioOeN ? hostDrv : linkOut.sdioOut};
    always #10 core_clk = ~core_clk;
    serial_control_port_target uut (.core_clk, .rst, .linkIn, .linkOut,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    host_model host (.core_clk, .linkOut, .useSep, .csN, .sclk, .hostDrv);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk
    task automatic axiW(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask : axiW
    task automatic axiR(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask : axiR
    // whole frame: instruction then n data bytes
    task automatic xfer(input logic [15:0] ins, input logic [31:0] d,
                        input int n, output logic [31:0] r);
        host.selLow();
        host.shift({16'h0, ins}, 16, junk);
        host.shift(d, 8 * n, r);
        host.selHigh();
    endtask : xfer
    task automatic done(input string n);
        $display("test %s ended, mismatches so far %0d", n, errors);
    endtask : done
    task automatic results();
        $display("comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        repeat (3) @(posedge core_clk);
        axiR(OFF_STATUS, rd, resp);
        chk(rd, 32'h0);
        chk(32'({linkOut.sdioOeN, linkOut.rbOeN}), 32'h3);
        axiR(8'h10, rd, resp);
        chk(32'(resp), 32'(RESP_SLVERR));
        axiW(8'h20, 32'h1, resp);
        chk(32'(resp), 32'(RESP_SLVERR));
        xfer(16'h8000, 32'h0, 1, rd);
        chk(rd, 32'h18);
        done("reset");
        // two-byte write stalled between data bytes
        host.selLow();
        host.shift(32'h2011, 16, junk);
        host.shift(32'hA5, 8, junk);
        host.selHigh();
        axiR(OFF_STATUS, rd, resp);
        chk(rd, 32'h3);
        host.selLow();
        host.shift(32'h3C, 8, junk);
        host.selHigh();
        axiW(OFF_PEEKADR, 32'h11, resp);
        axiR(OFF_PEEKDAT, rd, resp);
        chk(rd, 32'h0);
        xfer(16'hA011, 32'h0, 2, rd);
        chk(rd, 32'hA53C);
        done("stall");
        // stall in instruction, abort, then a torn byte
        host.selLow();
        host.shift(32'h0, 8, junk);
        host.selHigh();
        // status bit 5 keeps the direction of the last decoded instruction
        axiR(OFF_STATUS, rd, resp);
        chk(rd, 32'h23);
        host.selLow();
        host.shift(32'h0, 3, junk);
        host.selHigh();
        axiR(OFF_STATUS, rd, resp);
        chk(rd, 32'h20);
        host.selLow();
        host.shift(32'h0010, 16, junk);
        host.shift(32'h1F, 5, junk);
        host.selHigh();
        xfer(16'hA011, 32'h0, 2, rd);
        chk(rd, 32'hA53C);
        done("abort");
        // active readback after update
        xfer(16'h0004, 32'h1, 1, junk);
        xfer(16'h0232, 32'h1, 1, junk);
        axiR(OFF_PEEKDAT, rd, resp);
        chk(rd, 32'hA5);
        xfer(16'h0011, 32'h77, 1, junk);
        xfer(16'h8011, 32'h0, 1, rd);
        chk(rd, 32'hA5);
        done("update");
        // mirrored config moves readback to the separate line
        xfer(16'h0000, 32'h99, 1, junk);
        useSep <= 1'h1;
        axiR(OFF_STATUS, rd, resp);
        chk(rd, 32'h80);
        xfer(16'hE012, 32'h0, 4, rd);
        chk(rd, 32'h00A53C00);
        // stream from 0x001 stops after the top; released line reads high
        xfer(16'hE001, 32'h0, 4, rd);
        chk(rd, 32'h001800FF);
        axiR(OFF_BYTECNT, rd, resp);
        chk(rd, 32'h13);
        done("separate");
        // lsb first takes hold at once and the address climbs
        xfer(16'h0000, 32'hDB, 1, junk);
        xfer(16'h0805, 32'h0, 2, rd);
        chk(rd, 32'h3CA5);
        done("lsb");
        results();
    end
endmodule : tb
